// ===== src/tsas_pkg.sv
// Purpose: Shared constants for the touch acquisition status slice
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Offsets are byte addresses; widths are fixed
package tsas_pkg;

  // ****************************************************************
  // Geometry of the sensing groups
  // ****************************************************************
  localparam int unsigned TSAS_GROUPS = 7;  // Analog I/O groups
  localparam int unsigned TSAS_PINS = 4;  // Pins in each group
  localparam int unsigned TSAS_HYST_W = TSAS_GROUPS * TSAS_PINS;
  localparam int unsigned TSAS_CNT_W = 14;  // Group counter width

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned TSAS_ADR_W = 8;  // Byte address width
  localparam logic [7:0] TSAS_OFF_ICR = 8'h08;  // Interrupt clear
  localparam logic [7:0] TSAS_OFF_STATUS = 8'h0C;  // Status, read only
  localparam logic [7:0] TSAS_OFF_HYST = 8'h10;  // Hysteresis control

  // Status and clear bit positions
  localparam int unsigned TSAS_BIT_EOA = 0;  // Acquisition done
  localparam int unsigned TSAS_BIT_MCE = 1;  // Max count error

  // Reset values
  localparam logic [31:0] TSAS_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] TSAS_HYST_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] TSAS_ZERO = 32'h0000_0000;

endpackage

// ===== src/tsas_flag_if.sv
// Purpose: Carries set and clear events and flag values
// Assumes: All signals live on the one peripheral clock
// Notes:   ctrl side raises events, flags side keeps the flags
`timescale 1ns/1ps
`default_nettype none
interface tsas_flag_if;
  logic mce_set;  // Max count reached this cycle
  logic eoa_set;  // Acquisition complete this cycle
  logic mce_clr;  // Software clear of the error flag
  logic eoa_clr;  // Software clear of the done flag
  logic mce_flag;  // Sticky error flag
  logic eoa_flag;  // Sticky done flag

  // Event source and flag consumer
  modport ctrl (
    output mce_set, eoa_set, mce_clr, eoa_clr,
    input mce_flag, eoa_flag
  );

  // Flag keeper
  modport flags (
    input mce_set, eoa_set, mce_clr, eoa_clr,
    output mce_flag, eoa_flag
  );
endinterface
`default_nettype wire

// ===== src/tsas_flags.sv
// Purpose: Sticky status flags of the acquisition status register
// Assumes: Set and clear events are single-cycle, same clock
// Notes:   A set in the clearing cycle keeps the flag set
`timescale 1ns/1ps
`default_nettype none
module tsas_flags
  import tsas_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Events in, flags out
  tsas_flag_if.flags fl
);

  // ****************************************************************
  // Flag state
  // ****************************************************************
  logic mce_reg;  // Error flag
  logic mce_next;
  logic eoa_reg;  // Done flag
  logic eoa_next;

  // Next flag values: set has priority over clear
  always_comb begin
    mce_next = mce_reg;
    eoa_next = eoa_reg;
    if (fl.mce_clr) begin
      mce_next = 1'b0;
    end
    if (fl.mce_set) begin
      mce_next = 1'b1;
    end
    if (fl.eoa_clr) begin
      eoa_next = 1'b0;
    end
    if (fl.eoa_set) begin
      eoa_next = 1'b1;
    end
  end

  // Register the flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mce_reg <= TSAS_STATUS_RST[TSAS_BIT_MCE];
      eoa_reg <= TSAS_STATUS_RST[TSAS_BIT_EOA];
    end else begin
      mce_reg <= mce_next;
      eoa_reg <= eoa_next;
    end
  end

  assign fl.mce_flag = mce_reg;
  assign fl.eoa_flag = eoa_reg;

endmodule
`default_nettype wire

// ===== src/tsas_top.sv
// Purpose: Status and pin hysteresis registers of a touch controller
// Assumes: Group counters, done bits and max count share clk_i
// Notes:   Classic Wishbone slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
module tsas_top
  import tsas_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [TSAS_ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Acquisition engine
  input wire logic [TSAS_GROUPS*TSAS_CNT_W-1:0] group_count_i,
  input wire logic [TSAS_CNT_W-1:0] max_count_i,
  input wire logic [TSAS_GROUPS-1:0] group_enable_i,
  input wire logic [TSAS_GROUPS-1:0] group_acquisition_done_i,
  // Status and pad control
  output logic max_count_error_flag_o,
  output logic acquisition_done_flag_o,
  output logic [TSAS_HYST_W-1:0] group_pin_hysteresis_enable_o
);

  // ****************************************************************
  // Acquisition event detection
  // ****************************************************************
  logic [TSAS_GROUPS-1:0] group_at_max;  // Per-group max count hit
  logic max_count_error;  // Any enabled counter at max
  logic all_groups_done;  // Every enabled group finished

  // One comparator per group counter
  genvar g;
  generate
    for (g = 0; g < TSAS_GROUPS; g++) begin : g_cmp
      assign group_at_max[g] = group_enable_i[g] &&
        (group_count_i[g*TSAS_CNT_W +: TSAS_CNT_W] >= max_count_i);
    end
  endgenerate

  // Error as soon as any enabled counter gets there
  assign max_count_error = |group_at_max;
  // No enabled group means nothing to finish
  assign all_groups_done = (|group_enable_i) &&
    ((group_acquisition_done_i & group_enable_i) == group_enable_i);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic req;  // New request, not yet answered
  logic wr_fire;  // Write completes at this edge
  logic sel_icr;  // Address hits the clear register
  logic sel_status;  // Address hits the status register
  logic sel_hyst;  // Address hits the hysteresis register
  logic ack_reg;  // Answer strobe
  logic ack_next;
  logic [31:0] rdata_reg;  // Captured read data
  logic [31:0] rdata_next;

  assign req = cyc_i && stb_i && !ack_reg;
  // Writes land on the edge where the master samples ack
  assign wr_fire = cyc_i && stb_i && we_i && ack_reg;
  assign sel_icr = (adr_i == TSAS_OFF_ICR);
  assign sel_status = (adr_i == TSAS_OFF_STATUS);
  assign sel_hyst = (adr_i == TSAS_OFF_HYST);

  // ****************************************************************
  // Status flags
  // ****************************************************************
  tsas_flag_if flag_bus ();

  // Events into the flag keeper
  assign flag_bus.mce_set = max_count_error;
  // Error also marks the acquisition finished
  assign flag_bus.eoa_set = all_groups_done || max_count_error;
  // Write one clears, write zero leaves the flag alone
  assign flag_bus.mce_clr = wr_fire && sel_icr && sel_i[0] &&
    dat_i[TSAS_BIT_MCE];
  assign flag_bus.eoa_clr = wr_fire && sel_icr && sel_i[0] &&
    dat_i[TSAS_BIT_EOA];

  // Sticky flag keeper
  tsas_flags u_flags (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .fl (flag_bus)
  );

  // ****************************************************************
  // Hysteresis control register
  // ****************************************************************
  logic [31:0] hyst_reg;  // Pin hysteresis enables
  logic [31:0] hyst_next;

  // Byte-lane write; reserved top bits never change
  always_comb begin
    hyst_next = hyst_reg;
    if (wr_fire && sel_hyst) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          hyst_next[b*8 +: 8] = dat_i[b*8 +: 8];
        end
      end
    end
    hyst_next[31:TSAS_HYST_W] = TSAS_HYST_RST[31:TSAS_HYST_W];
  end

  // Register the enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_reg <= TSAS_HYST_RST;
    end else begin
      hyst_reg <= hyst_next;
    end
  end

  // Straight to the pads, whatever drives the pins otherwise
  assign group_pin_hysteresis_enable_o = hyst_reg[TSAS_HYST_W-1:0];

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Next ack and read data
  always_comb begin
    ack_next = req;
    rdata_next = rdata_reg;
    if (req) begin
      rdata_next = TSAS_ZERO;  // Clear register and holes read zero
      if (sel_status) begin
        rdata_next[TSAS_BIT_MCE] = flag_bus.mce_flag;
        rdata_next[TSAS_BIT_EOA] = flag_bus.eoa_flag;
      end else if (sel_hyst) begin
        rdata_next = hyst_reg;
      end
    end
  end

  // Register ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= TSAS_ZERO;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;
  assign max_count_error_flag_o = flag_bus.mce_flag;
  assign acquisition_done_flag_o = flag_bus.eoa_flag;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_status_ack;  // Status read answered this cycle
  logic rd_hyst_ack;  // Hysteresis read answered this cycle
  assign rd_status_ack = ack_o && !we_i && sel_status;
  assign rd_hyst_ack = ack_o && !we_i && sel_hyst;

  // Counter at max sets error next cycle
  a_mce_sets: assert property (
    max_count_error |=> max_count_error_flag_o)
    else $error("max count did not set error flag");

  // Error flag holds without a clear
  a_mce_holds: assert property (
    max_count_error_flag_o && !flag_bus.mce_clr
      |=> max_count_error_flag_o)
    else $error("error flag dropped without clear");

  // All enabled groups done sets done flag
  a_eoa_all_done: assert property (
    all_groups_done |=> acquisition_done_flag_o)
    else $error("done flag not set after all groups done");

  // Error marks acquisition done too
  a_eoa_on_error: assert property (
    max_count_error && !all_groups_done |=> acquisition_done_flag_o)
    else $error("done flag not set on max count error");

  // Done flag only falls after a clear write
  a_eoa_clear_only: assert property (
    $fell(acquisition_done_flag_o) |-> $past(flag_bus.eoa_clr))
    else $error("done flag fell without clear");

  // Status read shows both flags and zero above
  a_status_read: assert property (
    rd_status_ack |-> dat_o == {30'h0000_0000,
      $past(max_count_error_flag_o), $past(acquisition_done_flag_o)})
    else $error("status read data wrong");

  // Hysteresis enables all ones after reset
  a_hyst_reset: assert property (
    $past(rst_i) |-> group_pin_hysteresis_enable_o == '1)
    else $error("hysteresis enables not all ones after reset");

  // Full-word write reaches the pad enables
  a_hyst_write: assert property (
    wr_fire && sel_hyst && sel_i == 4'hF
      |=> group_pin_hysteresis_enable_o ==
        $past(dat_i[TSAS_HYST_W-1:0]))
    else $error("hysteresis write not applied");

  // Reserved hysteresis bits read as ones
  a_hyst_resv: assert property (
    rd_hyst_ack |-> dat_o[31:TSAS_HYST_W] == 4'hF)
    else $error("reserved hysteresis bits not one");

  // Set in the clearing cycle wins
  a_set_wins: assert property (
    flag_bus.mce_set && flag_bus.mce_clr
      |=> max_count_error_flag_o && acquisition_done_flag_o)
    else $error("clear beat a set event");

  // Ack is a single-cycle answer
  a_ack_pulse: assert property (
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  // Every taken request is answered on the next edge
  a_ack_answer: assert property (
    req |=> ack_o)
    else $error("request not answered after one cycle");

  // Done flag set event beats a clear in the same cycle
  a_eoa_set_wins: assert property (
    flag_bus.eoa_set && flag_bus.eoa_clr |=> acquisition_done_flag_o)
    else $error("clear beat a done set event");

  // Error flag only falls after a clear write
  a_mce_clear_only: assert property (
    $fell(max_count_error_flag_o) |-> $past(flag_bus.mce_clr))
    else $error("error flag fell without clear");

  // Clear without a set event drops the error flag
  a_mce_clears: assert property (
    flag_bus.mce_clr && !flag_bus.mce_set
      |=> !max_count_error_flag_o)
    else $error("error flag not cleared by write one");

  // Clear without a set event drops the done flag
  a_eoa_clears: assert property (
    flag_bus.eoa_clr && !flag_bus.eoa_set
      |=> !acquisition_done_flag_o)
    else $error("done flag not cleared by write one");

  // Writing zero to the done clear bit leaves the flag set
  a_zero_clr_noop: assert property (
    wr_fire && sel_icr && !dat_i[TSAS_BIT_EOA] &&
      acquisition_done_flag_o |=> acquisition_done_flag_o)
    else $error("zero clear write dropped done flag");

  // Pad enables only move on a hysteresis write
  a_hyst_keep: assert property (
    !(wr_fire && sel_hyst) |=> $stable(group_pin_hysteresis_enable_o))
    else $error("hysteresis enables changed without write");

  // Unmapped and clear register reads return zero
  a_unmapped_zero: assert property (
    ack_o && !we_i && !sel_status && !sel_hyst |-> dat_o == TSAS_ZERO)
    else $error("unmapped read data not zero");

  // Main scenarios
  c_error_then_clear: cover property (
    max_count_error_flag_o ##[1:20] !max_count_error_flag_o);
  c_done_read: cover property (
    rd_status_ack && dat_o[TSAS_BIT_EOA]);
  c_hyst_clear_bit: cover property (
    wr_fire && sel_hyst ##1 group_pin_hysteresis_enable_o != '1);
  c_mce_set_wins: cover property (
    flag_bus.mce_set && flag_bus.mce_clr);
  c_eoa_set_wins: cover property (
    flag_bus.eoa_set && flag_bus.eoa_clr);

endmodule
`default_nettype wire

// ===== tb/tsas_top_test.sv
// Purpose: Self-checking bench for the status and hysteresis slice
// Assumes: Classic Wishbone, one clock, synchronous active-high reset
// Notes:   Each scenario is a task that drives and judges on its own
`timescale 1ns/1ps
`default_nettype none
module tsas_top_test;
  import tsas_pkg::*;
  // ****************************************************************
  // Stimulus and observation signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [TSAS_ADR_W-1:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack_o;
  logic [TSAS_GROUPS*TSAS_CNT_W-1:0] cnt = '0;  // Group counters
  logic [TSAS_CNT_W-1:0] maxc = 14'h0100;  // Programmed max count
  logic [TSAS_GROUPS-1:0] gen = 7'h00;  // Enabled groups
  logic [TSAS_GROUPS-1:0] gdone = 7'h00;  // Per-group done bits
  logic mce_o;
  logic eoa_o;
  logic [TSAS_HYST_W-1:0] hyst_o;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] rd;  // Last read word

  // ****************************************************************
  // Design under test
  // ****************************************************************
  tsas_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .group_count_i(cnt),
    .max_count_i(maxc), .group_enable_i(gen),
    .group_acquisition_done_i(gdone),
    .max_count_error_flag_o(mce_o), .acquisition_done_flag_o(eoa_o),
    .group_pin_hysteresis_enable_o(hyst_o)
  );

  // Free-running 4 ns clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // Compare one value, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  // Flag outputs as seen two edges after an input change
  task automatic flags(input logic m, input logic e);
    repeat (2) @(posedge clk_i);
    chk({31'h0, mce_o}, {31'h0, m});
    chk({31'h0, eoa_o}, {31'h0, e});
    bus(1'b0, TSAS_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, {30'h0, m, e});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values of both registers and the pad enables
  task automatic t_reset;
    bus(1'b0, TSAS_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    bus(1'b0, TSAS_OFF_HYST, 32'h0, 4'hF);
    chk(rd, 32'hFFFF_FFFF);
    chk({4'h0, hyst_o}, 32'h0FFF_FFFF);
  endtask

  // Hysteresis write, byte lane, reserved top nibble
  task automatic t_hyst;
    bus(1'b1, TSAS_OFF_HYST, 32'hF000_5A5A, 4'hF);
    bus(1'b1, TSAS_OFF_HYST, 32'hFFFF_FF00, 4'h1);
    bus(1'b0, TSAS_OFF_HYST, 32'h0, 4'hF);
    chk(rd, 32'hF000_5A00);
    chk({4'h0, hyst_o}, 32'h0000_5A00);
    bus(1'b1, TSAS_OFF_STATUS, 32'h0000_0003, 4'hF);
    bus(1'b0, 8'h40, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
    bus(1'b0, TSAS_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h0000_0000);
  endtask

  // Max count on a disabled, then an enabled group; clears
  task automatic t_mce;
    cnt[2*TSAS_CNT_W +: TSAS_CNT_W] <= 14'h0100;
    gen <= 7'h01;
    flags(1'b0, 1'b0);
    gen <= 7'h04;
    flags(1'b1, 1'b1);
    bus(1'b1, TSAS_OFF_ICR, 32'h2, 4'h1);
    flags(1'b1, 1'b1);
    cnt <= '0;
    bus(1'b1, TSAS_OFF_ICR, 32'h0, 4'h1);
    flags(1'b1, 1'b1);
    bus(1'b1, TSAS_OFF_ICR, 32'h2, 4'h1);
    flags(1'b0, 1'b1);
    bus(1'b1, TSAS_OFF_ICR, 32'h1, 4'h1);
    flags(1'b0, 1'b0);
  endtask

  // Completion of all enabled groups; set beats clear
  task automatic t_done;
    gen <= 7'h05;
    gdone <= 7'h01;
    flags(1'b0, 1'b0);
    gdone <= 7'h05;
    flags(1'b0, 1'b1);
    bus(1'b1, TSAS_OFF_ICR, 32'h1, 4'h1);
    flags(1'b0, 1'b1);
    gdone <= 7'h00;
    bus(1'b1, TSAS_OFF_ICR, 32'h1, 4'h1);
    flags(1'b0, 1'b0);
  endtask

  // Counts, then verdict, then end of run
  task automatic print_verdict;
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_hyst;
    t_mce;
    t_done;
    print_verdict;
  end

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #40000;
    n_mismatch++;
    print_verdict;
  end
endmodule
`default_nettype wire
